/* bic_pkg.sv */
package bic_pkg;
   localparam int NUM_IN = 8;
   localparam int FT_W = 27;
   localparam int ADDR_W = 9;
   localparam logic [26:0] FILT_MAX_MS = 27'h526_5C00;
   localparam int CLK_NS = 10;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES = MS_NS / CLK_NS;
   localparam logic [5:0] POS_MAX = 6'h3E;
   localparam logic [5:0] POS_INVALID = 6'h3F;
   localparam logic [5:0] BCD_TEN = 6'h0A;
   localparam logic [2:0] TAP_BITS_MAX = 3'h6;
   localparam logic [ADDR_W-1:0] REG_POLARITY = 9'h000;
   localparam logic [ADDR_W-1:0] REG_DP_MASK = 9'h004;
   localparam logic [ADDR_W-1:0] REG_RETRIG = 9'h008;
   localparam logic [ADDR_W-1:0] REG_SUPPRESS = 9'h00C;
   localparam logic [ADDR_W-1:0] REG_CHAT_EN = 9'h010;
   localparam logic [ADDR_W-1:0] REG_CHAT_CFG = 9'h014;
   localparam logic [ADDR_W-1:0] REG_TAP_CFG = 9'h018;
   localparam logic [ADDR_W-1:0] REG_PCNT_CFG = 9'h01C;
   localparam logic [ADDR_W-1:0] REG_PCNT_FACTOR = 9'h020;
   localparam logic [ADDR_W-1:0] REG_SP_STATE = 9'h024;
   localparam logic [ADDR_W-1:0] REG_DP_STATE = 9'h028;
   localparam logic [ADDR_W-1:0] REG_TAP_STATE = 9'h02C;
   localparam logic [ADDR_W-1:0] REG_PCNT_RAW = 9'h030;
   localparam logic [ADDR_W-1:0] REG_PCNT_VALUE = 9'h034;
   localparam logic [ADDR_W-1:0] REG_CHAT_BLOCKED = 9'h038;
   localparam logic [ADDR_W-1:0] REG_FILT_BASE = 9'h040;
   localparam logic [ADDR_W-1:0] REG_TBL_BASE = 9'h100;
   typedef enum logic [1:0] {ENC_BINARY, ENC_BCD, ENC_ONE_OF_N, ENC_TABLE} bic_enc_type;
   typedef struct packed {
      logic [7:0] offset;
      logic [7:0] step;
      logic [5:0] npos;
      logic [2:0] nbits;
      logic [2:0] first;
      bic_enc_type enc;
   } bic_tap_cfg_type;
   typedef struct packed {
      logic [11:0] win_ms;
      logic [3:0] limit;
   } bic_chat_cfg_type;
   typedef struct packed {
      logic neg;
      logic dbl;
      logic [2:0] sel;
   } bic_pcnt_cfg_type;
endpackage

/* bic_filter.sv */
`timescale 1ns/100ps
module bic_filter
   import bic_pkg::*;
(
   input  wire logic             clk,      // system clock
   input  wire logic             rst_n,    // synchronised reset
   input  wire logic [1:0]       lvl,      // conditioned level
   input  wire logic             ms_tick,  // millisecond enable
   input  wire logic [FT_W-1:0]  ftime,    // filter interval in ms
   input  wire logic             retrig,   // restart on change
   input  wire logic             bypass,   // forward at once
   input  wire logic             chat_en,  // chatter blocking on
   input  wire logic [3:0]       chat_lim, // changes per window
   input  wire logic             win_tick, // chatter window end
   output logic [1:0]            out_ff,   // forwarded state
   output logic                  blocked   // chatter block active
);
   logic [FT_W-1:0] cnt_ff;
   logic            run_ff;
   logic [1:0]      last_ff;
   logic [3:0]      chg_cnt_ff;
   wire chg = lvl != out_ff;
   wire moved = lvl != last_ff;
   wire expire = run_ff & ms_tick & ((cnt_ff + 1'b1) >= ftime);
   assign blocked = chat_en & (chat_lim != 4'h0) & (chg_cnt_ff >= chat_lim); // RQ6
   // same interval for both directions
   wire fwd = chg & ~blocked & (bypass | (ftime == '0) | expire); // RQ1 RQ3 RQ5

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_ff <= 2'h0;
         last_ff <= 2'h0;
         chg_cnt_ff <= 4'h0;
      end else begin
         last_ff <= lvl;
         if (fwd) out_ff <= lvl;
         if (win_tick) chg_cnt_ff <= 4'h0;
         else if (fwd && chg_cnt_ff != 4'hF) chg_cnt_ff <= chg_cnt_ff + 4'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         run_ff <= 1'b0;
         cnt_ff <= '0;
      end else if (fwd || (expire && !chg)) begin
         run_ff <= 1'b0;
         cnt_ff <= '0;
      end else if (!run_ff && chg) begin
         run_ff <= 1'b1;
         cnt_ff <= '0;
      end else if (run_ff && retrig && moved) begin // RQ4
         run_ff <= chg;
         cnt_ff <= '0;
      end else if (run_ff && ms_tick && !expire) begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end
endmodule // bic_filter

/* bic_tap_decoder.sv */
`timescale 1ns/100ps
module bic_tap_decoder
   import bic_pkg::*;
(
   input  wire logic              clk,      // system clock
   input  wire logic              rst_n,    // synchronised reset
   input  wire logic [NUM_IN-1:0] vec,      // filtered inputs
   input  bic_pkg::bic_tap_cfg_type cfg,    // decoder setup
   input  wire logic              tbl_we,   // table write
   input  wire logic [5:0]        tbl_addr, // table pattern
   input  wire logic [5:0]        tbl_data, // table position
   output logic [5:0]             code_ff,  // position 1..62 or 63
   output logic [15:0]            disp_ff   // scaled display value
);
   logic [5:0] tbl [64];
   function automatic logic [5:0] onehot_pos(input logic [5:0] p, input logic [2:0] n);
      logic [5:0] r;
      r = 6'h00;
      for (int k = 0; k < 6; k++) begin
         if (k < n && p[k]) r = (r == 6'h00) ? 6'(k + 1) : POS_INVALID;
      end
      return r;
   endfunction
   wire [2:0] nb = (cfg.nbits > TAP_BITS_MAX) ? TAP_BITS_MAX : cfg.nbits; // RQ13
   wire [NUM_IN-1:0] sh = vec >> cfg.first; // RQ8
   wire [5:0] mask = 6'((7'h01 << nb) - 7'h01);
   wire [5:0] pat = sh[5:0] & mask;
   wire bcd_bad = pat[3:0] > 4'h9;
   wire [5:0] bcd = 6'(pat[5:4] * BCD_TEN) + {2'h0, pat[3:0]};
   logic [5:0] raw;
   always_comb begin
      case (cfg.enc) // RQ9 RQ10
         ENC_BINARY: raw = pat;
         ENC_BCD: raw = bcd_bad ? POS_INVALID : bcd;
         ENC_ONE_OF_N: raw = onehot_pos(pat, nb);
         ENC_TABLE: raw = tbl[pat];
         default: raw = POS_INVALID;
      endcase
   end
   // a code outside 1..npos is unusable even if it decodes
   wire ok = (raw != 6'h00) && (raw <= cfg.npos) && (raw <= POS_MAX); // RQ7 RQ11 RQ21
   wire [5:0] code = ok ? raw : POS_INVALID; // RQ12
   wire [15:0] disp = 16'(code) * 16'(cfg.step) + {8'h00, cfg.offset}; // RQ14

   always_ff @(posedge clk) begin
      if (tbl_we) tbl[tbl_addr] <= tbl_data;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         code_ff <= POS_INVALID;
         disp_ff <= 16'h0000;
      end else begin
         code_ff <= code;
         disp_ff <= ok ? disp : {10'h000, POS_INVALID};
      end
   end
endmodule // bic_tap_decoder

/* bic_top.sv */
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/100ps
// Contract
// (RQ1) forward a change only after it held for the filter interval in ms
// (RQ2) filter interval accepts zero up to one day in ms
// (RQ3) same filter interval for asserting and deasserting changes
// (RQ4) per indication option: a change during filtering restarts the interval
// (RQ5) with suppression, double point end positions pass at once, intermediate filtered
// (RQ6) chatter blocking enabled per indication, its parameters shared by all
// (RQ7) tap decoder yields at most sixty-two valid positions
// (RQ8) tap inputs are a contiguous run of consecutive inputs
// (RQ9) binary, BCD and one-of-n with positions, bits, offset and step
// (RQ10) with no standard encoding a loaded table maps patterns
// (RQ11) recognised patterns give positions one to sixty-two
// (RQ12) unrecognised patterns report position sixty-three
// (RQ13) bit count equals decoder inputs and bounds positions
// (RQ14) display equals decoded value times step plus offset
// (RQ15) single pulse mode counts one per complete pulse
// (RQ16) double transition mode counts every rising and falling edge
// (RQ17) metered value is raw count divided by conversion factor
// (RQ18) metered value sign follows configured power flow direction
// (RQ19) each input active high or active low
// (RQ20) double point takes the next input too; releasing frees both
// (RQ21) zero or beyond configured positions also reports invalid
// (RQ22) double point: opposite inputs are end positions, equal is intermediate
module bic_top
   import bic_pkg::*;
#(
   parameter int MS_DIV = MS_CYCLES
) (
   input  wire logic              sys_clk,    // 100 MHz clock
   input  wire logic              rst_b,      // async reset, active low
   input  wire logic [NUM_IN-1:0] bin_in,     // field contact pins
   input  wire logic [ADDR_W-1:0] reg_addr,   // register byte address
   input  wire logic [31:0]       reg_wdata,  // write data
   input  wire logic              reg_wr,     // write strobe
   input  wire logic              reg_rd,     // read strobe
   output logic [31:0]            reg_rdata,  // read data, next cycle
   output logic [NUM_IN-1:0]      sp_ind,     // single point states
   output logic [2*NUM_IN-1:0]    dp_ind,     // double point pairs
   output logic [5:0]             tap_code,   // tap position code
   output logic [15:0]            tap_disp,   // tap display value
   output logic [31:0]            pcnt_value  // signed metered value
);
   import bic_pkg::*;

   logic [1:0] rst_sync_ff;
   wire rst_n = rst_sync_ff[1];
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) rst_sync_ff <= 2'h0;
      else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
   end

   // pins are asynchronous to sys_clk
   logic [NUM_IN-1:0] pin_s1_ff;
   logic [NUM_IN-1:0] pin_s2_ff;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_ff <= '0;
         pin_s2_ff <= '0;
      end else begin
         pin_s1_ff <= bin_in;
         pin_s2_ff <= pin_s1_ff;
      end
   end

   // millisecond enable; shorten MS_DIV in simulation
   logic [31:0] ms_cnt_ff;
   logic        ms_tick_ff;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ms_cnt_ff <= 32'h0000_0000;
         ms_tick_ff <= 1'b0;
      end else begin
         ms_tick_ff <= ms_cnt_ff == 32'(MS_DIV - 1);
         ms_cnt_ff <= (ms_cnt_ff == 32'(MS_DIV - 1)) ? 32'h0000_0000 : ms_cnt_ff + 32'h0000_0001;
      end
   end

   logic [NUM_IN-1:0] pol_ff;
   logic [NUM_IN-1:0] dp_mask_ff;
   logic [NUM_IN-1:0] retrig_ff;
   logic [NUM_IN-1:0] supp_ff;
   logic [NUM_IN-1:0] chat_en_ff;
   bic_chat_cfg_type  chat_cfg_ff;
   bic_tap_cfg_type   tap_cfg_ff;
   bic_pcnt_cfg_type  pcnt_cfg_ff;
   logic [15:0]       factor_ff;
   logic [FT_W-1:0]   ftime_ff [NUM_IN];

   function automatic logic is_filt(input logic [ADDR_W-1:0] a);
      return (a >= REG_FILT_BASE) && (a < REG_FILT_BASE + 9'(4 * NUM_IN));
   endfunction
   function automatic logic [2:0] filt_idx(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] d;
      d = a - REG_FILT_BASE;
      return d[4:2];
   endfunction

   wire wr_pol = reg_wr && reg_addr == REG_POLARITY;
   wire wr_dp = reg_wr && reg_addr == REG_DP_MASK;
   wire wr_rtg = reg_wr && reg_addr == REG_RETRIG;
   wire wr_sup = reg_wr && reg_addr == REG_SUPPRESS;
   wire wr_cen = reg_wr && reg_addr == REG_CHAT_EN;
   wire wr_ccfg = reg_wr && reg_addr == REG_CHAT_CFG;
   wire wr_tap = reg_wr && reg_addr == REG_TAP_CFG;
   wire wr_pcfg = reg_wr && reg_addr == REG_PCNT_CFG;
   wire wr_fac = reg_wr && reg_addr == REG_PCNT_FACTOR;
   wire wr_praw = reg_wr && reg_addr == REG_PCNT_RAW;
   wire wr_filt = reg_wr && is_filt(reg_addr);
   wire wr_tbl = reg_wr && reg_addr[8];
   // oversize intervals are clamped to one day
   wire [FT_W-1:0] ft_wr = (reg_wdata > {5'h00, FILT_MAX_MS}) ? FILT_MAX_MS : reg_wdata[FT_W-1:0]; // RQ2

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pol_ff <= '0;
         dp_mask_ff <= '0;
         retrig_ff <= '0;
         supp_ff <= '0;
         chat_en_ff <= '0;
      end else begin
         if (wr_pol) pol_ff <= reg_wdata[NUM_IN-1:0];
         if (wr_dp) dp_mask_ff <= reg_wdata[NUM_IN-1:0];
         if (wr_rtg) retrig_ff <= reg_wdata[NUM_IN-1:0];
         if (wr_sup) supp_ff <= reg_wdata[NUM_IN-1:0];
         if (wr_cen) chat_en_ff <= reg_wdata[NUM_IN-1:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         chat_cfg_ff <= '0;
         tap_cfg_ff <= '0;
         pcnt_cfg_ff <= '0;
         factor_ff <= 16'h0001;
      end else begin
         if (wr_ccfg) chat_cfg_ff <= reg_wdata[15:0];
         if (wr_tap) tap_cfg_ff <= reg_wdata[29:0];
         if (wr_pcfg) pcnt_cfg_ff <= reg_wdata[4:0];
         if (wr_fac) factor_ff <= reg_wdata[15:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int k = 0; k < NUM_IN; k++) ftime_ff[k] <= '0;
      end else if (wr_filt) begin
         ftime_ff[filt_idx(reg_addr)] <= ft_wr;
      end
   end

   // shared chatter window, counted in ms
   logic [11:0] win_cnt_ff;
   wire win_tick = ms_tick_ff && (win_cnt_ff + 12'h001 >= chat_cfg_ff.win_ms);
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) win_cnt_ff <= 12'h000;
      else if (win_tick) win_cnt_ff <= 12'h000;
      else if (ms_tick_ff) win_cnt_ff <= win_cnt_ff + 12'h001;
   end

   wire [NUM_IN-1:0] act = pin_s2_ff ^ pol_ff; // RQ19
   logic [NUM_IN-1:0] dp_eff;
   logic [NUM_IN-1:0] taken;
   logic [1:0]        filt_out [NUM_IN];
   logic [NUM_IN-1:0] blk;
   logic [NUM_IN-1:0] sp_vec;
   logic [2*NUM_IN-1:0] dp_vec;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_IN; gi++) begin : g_in
         // a pair never overlaps a neighbour already claimed as partner
         if (gi == 0) begin : g_first
            assign dp_eff[gi] = dp_mask_ff[gi]; // RQ20
            assign taken[gi] = 1'b0;
         end else if (gi == NUM_IN - 1) begin : g_last
            assign dp_eff[gi] = 1'b0;
            assign taken[gi] = dp_eff[gi-1];
         end else begin : g_mid
            assign dp_eff[gi] = dp_mask_ff[gi] & ~dp_eff[gi-1]; // RQ20
            assign taken[gi] = dp_eff[gi-1];
         end
         wire [1:0] lvl;
         if (gi == NUM_IN - 1) begin : g_lvl_last
            assign lvl = {1'b0, act[gi]};
         end else begin : g_lvl
            assign lvl = dp_eff[gi] ? {act[gi+1], act[gi]} : {1'b0, act[gi]};
         end
         // opposite inputs mark a defined end position
         wire end_pos = dp_eff[gi] & (lvl[0] ^ lvl[1]); // RQ22
         bic_filter u_filt (
            .clk      (sys_clk),
            .rst_n    (rst_n),
            .lvl      (lvl),
            .ms_tick  (ms_tick_ff),
            .ftime    (ftime_ff[gi]),
            .retrig   (retrig_ff[gi]),
            .bypass   (end_pos & supp_ff[gi]),
            .chat_en  (chat_en_ff[gi]),
            .chat_lim (chat_cfg_ff.limit),
            .win_tick (win_tick),
            .out_ff   (filt_out[gi]),
            .blocked  (blk[gi])
         ); // RQ5 RQ6
         assign sp_vec[gi] = filt_out[gi][0] & ~dp_eff[gi] & ~taken[gi];
         assign dp_vec[2*gi+1:2*gi] = dp_eff[gi] ? filt_out[gi] : 2'h0;
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sp_ind <= '0;
         dp_ind <= '0;
      end else begin
         sp_ind <= sp_vec;
         dp_ind <= dp_vec;
      end
   end

   bic_tap_decoder u_tap (
      .clk      (sys_clk),
      .rst_n    (rst_n),
      .vec      (sp_vec),
      .cfg      (tap_cfg_ff),
      .tbl_we   (wr_tbl),
      .tbl_addr (reg_addr[7:2]),
      .tbl_data (reg_wdata[5:0]),
      .code_ff  (tap_code),
      .disp_ff  (tap_disp)
   ); // RQ7 RQ9 RQ10

   // pulse metering on the filtered level of the selected input
   logic        src_prev_ff;
   logic [31:0] raw_ff;
   logic [15:0] pre_ff;
   logic [31:0] units_ff;
   wire src = sp_vec[pcnt_cfg_ff.sel];
   wire rise = src & ~src_prev_ff;
   wire fall = ~src & src_prev_ff;
   // a pulse is complete at its trailing edge
   wire pulse = pcnt_cfg_ff.dbl ? (rise | fall) : fall; // RQ15 RQ16
   wire [15:0] fac = (factor_ff == 16'h0000) ? 16'h0001 : factor_ff;
   wire unit_done = pulse && (pre_ff + 16'h0001 >= fac); // RQ17

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         src_prev_ff <= 1'b0;
         raw_ff <= 32'h0000_0000;
         pre_ff <= 16'h0000;
         units_ff <= 32'h0000_0000;
      end else begin
         src_prev_ff <= src;
         if (wr_praw) begin
            raw_ff <= 32'h0000_0000;
            pre_ff <= 16'h0000;
            units_ff <= 32'h0000_0000;
         end else if (pulse) begin
            raw_ff <= raw_ff + 32'h0000_0001;
            pre_ff <= unit_done ? 16'h0000 : pre_ff + 16'h0001;
            if (unit_done) units_ff <= units_ff + 32'h0000_0001;
         end
      end
   end

   wire [31:0] signed_units = pcnt_cfg_ff.neg ? (32'h0000_0000 - units_ff) : units_ff; // RQ18
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) pcnt_value <= 32'h0000_0000;
      else pcnt_value <= signed_units;
   end

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (is_filt(reg_addr)) rd_mux = {5'h00, ftime_ff[filt_idx(reg_addr)]};
      else begin
         case (reg_addr)
            REG_POLARITY: rd_mux = {24'h00_0000, pol_ff};
            REG_DP_MASK: rd_mux = {24'h00_0000, dp_mask_ff};
            REG_RETRIG: rd_mux = {24'h00_0000, retrig_ff};
            REG_SUPPRESS: rd_mux = {24'h00_0000, supp_ff};
            REG_CHAT_EN: rd_mux = {24'h00_0000, chat_en_ff};
            REG_CHAT_CFG: rd_mux = {16'h0000, chat_cfg_ff};
            REG_TAP_CFG: rd_mux = {2'h0, tap_cfg_ff};
            REG_PCNT_CFG: rd_mux = {27'h000_0000, pcnt_cfg_ff};
            REG_PCNT_FACTOR: rd_mux = {16'h0000, factor_ff};
            REG_SP_STATE: rd_mux = {24'h00_0000, sp_ind};
            REG_DP_STATE: rd_mux = {16'h0000, dp_ind};
            REG_TAP_STATE: rd_mux = {tap_disp, 10'h000, tap_code};
            REG_PCNT_RAW: rd_mux = raw_ff;
            REG_PCNT_VALUE: rd_mux = pcnt_value;
            REG_CHAT_BLOCKED: rd_mux = {24'h00_0000, blk};
            default: rd_mux = 32'h0000_0000;
         endcase
      end
   end

   // data valid only in the cycle after the strobe
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) reg_rdata <= 32'h0000_0000;
      else reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
   end
endmodule // bic_top

/* bic_top_properties.sv */
`timescale 1ns/100ps
module bic_top_properties
   import bic_pkg::*;
(
   input logic              sys_clk,    // clock
   input logic              rst_b,      // async reset
   input logic [ADDR_W-1:0] reg_addr,   // address
   input logic              reg_rd,     // read strobe
   input logic [31:0]       reg_rdata,  // read data
   input logic [NUM_IN-1:0] sp_ind,     // single states
   input logic [15:0]       dp_ind,     // pair states
   input logic [5:0]        tap_code,   // tap code
   input logic [15:0]       tap_disp,   // tap display
   input logic [31:0]       pcnt_value  // metered value
);
   logic [2:0] up_cnt_ff;
   // decode settles after reset
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) up_cnt_ff <= 3'h0;
      else if (up_cnt_ff != 3'h7) up_cnt_ff <= up_cnt_ff + 3'h1;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   sequence s_rd_tap;
      (reg_rd && reg_addr == REG_TAP_STATE) ##1 ($stable(tap_code) && $stable(tap_disp));
   endsequence
   sequence s_rd_sp;
      (reg_rd && reg_addr == REG_SP_STATE) ##1 $stable(sp_ind);
   endsequence
   sequence s_rd_cnt;
      (reg_rd && reg_addr == REG_PCNT_VALUE) ##1 $stable(pcnt_value);
   endsequence
   AST_TAP_NONZERO: assert property (tap_code != 6'h00)
      else $error("tap code zero");
   AST_TAP_INV_DISP: assert property ((up_cnt_ff == 3'h7 && tap_code == POS_INVALID) |-> tap_disp == 16'h003F)
      else $error("invalid tap without invalid display");
   AST_TAP_READ: assert property (s_rd_tap |-> reg_rdata == {tap_disp, 10'h000, tap_code})
      else $error("tap state read mismatch");
   AST_SP_READ: assert property (s_rd_sp |-> reg_rdata == {24'h00_0000, sp_ind})
      else $error("single state read mismatch");
   AST_PCNT_READ: assert property (s_rd_cnt |-> reg_rdata == pcnt_value)
      else $error("metered read mismatch");
   AST_UNMAPPED: assert property ((reg_rd && (reg_addr == 9'h03C || reg_addr[8])) |=> reg_rdata == 32'h0000_0000)
      else $error("unmapped or table read not zero");
   AST_PCNT_STEP: assert property ($changed(pcnt_value) |-> (pcnt_value - $past(pcnt_value)) inside {32'h0000_0001,
      32'hFFFF_FFFF} || pcnt_value == 32'h0000_0000 || pcnt_value == -$past(pcnt_value))
      else $error("metered value jumped");
   AST_DP_TOP_ZERO: assert property (dp_ind[15:14] == 2'b00)
      else $error("last input formed a pair");
   for (genvar i = 0; i < NUM_IN - 1; i++) begin : g_pair
      AST_DP_FREES_SP: assert property ((dp_ind[2*i+:2] != 2'b00) |-> sp_ind[i+:2] == 2'b00)
         else $error("paired input shows single state");
   end
endmodule // bic_top_properties

bind bic_top bic_top_properties chk_u (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .sp_ind(sp_ind), .dp_ind(dp_ind), .tap_code(tap_code), .tap_disp(tap_disp),
   .pcnt_value(pcnt_value));

/* bic_field_model.sv */
`timescale 1ns/100ps
module bic_field_model
   import bic_pkg::*;
(
   input  wire logic         clk,  // system clock
   output logic [NUM_IN-1:0] pins  // contact levels
);
   initial pins = 8'h00;
   task automatic set_pins(input logic [NUM_IN-1:0] mask, input logic [NUM_IN-1:0] val);
      @(posedge clk);
      pins <= (pins & ~mask) | (val & mask);
   endtask
   task automatic pulses(input int idx, input int n);
      for (int k = 0; k < n; k++) begin
         set_pins(8'h01 << idx, 8'hFF);
         repeat (3) @(posedge clk);
         set_pins(8'h01 << idx, 8'h00);
         repeat (3) @(posedge clk);
      end
   endtask
endmodule // bic_field_model

/* bic_top_test.sv */
`timescale 1ns/100ps
module bic_top_test;
   import bic_pkg::*;
   logic              sys_clk, rst_b, reg_wr, reg_rd;
   logic [ADDR_W-1:0] reg_addr;
   logic [31:0]       reg_wdata, reg_rdata, pcnt_value;
   wire [NUM_IN-1:0]  bin_in;
   logic [NUM_IN-1:0] sp_ind;
   logic [15:0]       dp_ind, tap_disp;
   logic [5:0]        tap_code;
   int                mismatches = 0, num_checks = 0, cyc = 0;
   bic_field_model field_u (.clk(sys_clk), .pins(bin_in));
   bic_top #(.MS_DIV(10)) dut_u (.*);
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, exp);
   endtask
   task automatic drive(input logic [7:0] m, input logic [7:0] v, input int n);
      field_u.set_pins(m, v);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic tap_case(input [1:0] enc, input [2:0] bits, input [5:0] npos, input [5:0] pat,
      input [5:0] code);
      logic [15:0] disp;
      disp = (code == POS_INVALID) ? 16'h003F : {10'h000, code} * 16'h0002 + 16'h0002;
      wr(REG_TAP_CFG, {2'h0, 8'h02, 8'h02, npos, bits, 3'h0, enc});
      drive(8'h3F, {2'h0, pat}, 8);
      check(tap_code, code);
      check(tap_disp, disp);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 30000) begin
         mismatches++;
         wrap_up();
      end
   end
   initial begin
      {reg_wr, reg_rd, rst_b} = 3'h0;
      reg_addr = 9'h000;
      reg_wdata = 32'h0000_0000;
      repeat (16) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge sys_clk);
      check(tap_code, POS_INVALID);
      rd(REG_POLARITY, 8'h00);
      rd(REG_PCNT_FACTOR, 8'h01);
      rd(REG_SP_STATE, 8'h00);
      rd(9'h03C, 8'h00);
      rd(REG_TBL_BASE, 8'h00);
      wr(REG_FILT_BASE, 32'hFFFF_FFFF);
      rd(REG_FILT_BASE, {5'h00, FILT_MAX_MS});
      wr(REG_FILT_BASE, 32'h0526_5C00);
      rd(REG_FILT_BASE, 32'h0526_5C00);
      wr(REG_FILT_BASE, 8'h00);
      wr(REG_POLARITY, 8'h04);
      drive(8'h00, 8'h00, 8);
      check(sp_ind[2], 1'b1);
      drive(8'h04, 8'h04, 8);
      check(sp_ind[2], 1'b0);
      wr(REG_POLARITY, 8'h00);
      drive(8'h04, 8'h00, 8);
      $display("regs done");
      wr(REG_FILT_BASE + 9'h004, 8'h03);
      drive(8'h02, 8'h02, 15);
      drive(8'h02, 8'h00, 60);
      check(sp_ind[1], 1'b0);
      drive(8'h02, 8'h02, 15);
      check(sp_ind[1], 1'b0);
      drive(8'h00, 8'h00, 30);
      check(sp_ind[1], 1'b1);
      drive(8'h02, 8'h00, 15);
      check(sp_ind[1], 1'b1);
      drive(8'h00, 8'h00, 30);
      check(sp_ind[1], 1'b0);
      wr(REG_FILT_BASE + 9'h004, 8'h05);
      for (int r = 0; r < 2; r++) begin
         wr(REG_RETRIG, (r == 1) ? 8'h02 : 8'h00);
         drive(8'h02, 8'h02, 20);
         drive(8'h02, 8'h00, 2);
         drive(8'h02, 8'h02, 36);
         check(sp_ind[1], r == 0);
         drive(8'h00, 8'h00, 40);
         check(sp_ind[1], 1'b1);
         drive(8'h02, 8'h00, 70);
      end
      wr(REG_RETRIG, 8'h00);
      wr(REG_FILT_BASE + 9'h004, 8'h00);
      $display("filter done");
      wr(REG_FILT_BASE + 9'h010, 8'h05);
      wr(REG_FILT_BASE + 9'h014, 8'h05);
      wr(REG_DP_MASK, 8'h10);
      wr(REG_SUPPRESS, 8'h10);
      drive(8'h30, 8'h10, 8);
      check(dp_ind[9:8], 2'b01);
      check(sp_ind[5:4], 2'b00);
      drive(8'h30, 8'h30, 8);
      check(dp_ind[9:8], 2'b01);
      drive(8'h00, 8'h00, 60);
      check(dp_ind[9:8], 2'b11);
      drive(8'h30, 8'h20, 8);
      check(dp_ind[9:8], 2'b10);
      wr(REG_DP_MASK, 8'h00);
      wr(REG_SUPPRESS, 8'h00);
      drive(8'h00, 8'h00, 60);
      check(sp_ind[5:4], 2'b10);
      check(dp_ind[9:8], 2'b00);
      wr(REG_DP_MASK, 8'h10);
      drive(8'h30, 8'h10, 8);
      check(dp_ind[9:8], 2'b00);
      drive(8'h00, 8'h00, 60);
      check(dp_ind[9:8], 2'b01);
      wr(REG_DP_MASK, 8'h00);
      wr(REG_FILT_BASE + 9'h010, 8'h00);
      wr(REG_FILT_BASE + 9'h014, 8'h00);
      drive(8'h30, 8'h00, 8);
      $display("pairs done");
      wr(REG_CHAT_CFG, {16'h0000, 12'h064, 4'h2});
      wr(REG_CHAT_EN, 8'h40);
      for (int k = 0; k < 3; k++) drive(8'hC0, (k == 1) ? 8'h00 : 8'hC0, 5);
      check(sp_ind[7:6], 2'b10);
      rd(REG_CHAT_BLOCKED, 8'h40);
      drive(8'h00, 8'h00, 1100);
      check(sp_ind[6], 1'b1);
      wr(REG_CHAT_EN, 8'h00);
      drive(8'hC0, 8'h00, 8);
      $display("chatter done");
      tap_case(ENC_BINARY, 3'h3, 6'h04, 6'h00, POS_INVALID);
      tap_case(ENC_BINARY, 3'h3, 6'h04, 6'h01, 6'h01);
      tap_case(ENC_BINARY, 3'h3, 6'h04, 6'h04, 6'h04);
      tap_case(ENC_BINARY, 3'h3, 6'h04, 6'h05, POS_INVALID);
      tap_case(ENC_BINARY, 3'h2, 6'h04, 6'h04, POS_INVALID);
      tap_case(ENC_BINARY, 3'h6, 6'h3E, 6'h3F, POS_INVALID);
      tap_case(ENC_BINARY, 3'h6, 6'h3E, 6'h3E, 6'h3E);
      rd(REG_TAP_STATE, 32'h007E_003E);
      tap_case(ENC_BCD, 3'h5, 6'h14, 6'h12, 6'h0C);
      tap_case(ENC_BCD, 3'h5, 6'h14, 6'h0A, POS_INVALID);
      tap_case(ENC_ONE_OF_N, 3'h3, 6'h03, 6'h04, 6'h03);
      tap_case(ENC_ONE_OF_N, 3'h3, 6'h03, 6'h03, POS_INVALID);
      for (int p = 0; p < 8; p++) wr(REG_TBL_BASE + 9'(4 * p), (p == 3) ? 8'h07 : ((p == 5) ? 8'h28 : 8'h00));
      tap_case(ENC_TABLE, 3'h3, 6'h0A, 6'h03, 6'h07);
      tap_case(ENC_TABLE, 3'h3, 6'h0A, 6'h05, POS_INVALID);
      tap_case(ENC_TABLE, 3'h3, 6'h0A, 6'h02, POS_INVALID);
      drive(8'h3F, 8'h00, 8);
      $display("tap done");
      wr(REG_PCNT_CFG, 8'h07);
      wr(REG_PCNT_FACTOR, 8'h02);
      wr(REG_PCNT_RAW, 8'h00);
      field_u.pulses(7, 5);
      drive(8'h00, 8'h00, 8);
      rd(REG_PCNT_RAW, 8'h05);
      rd(REG_PCNT_VALUE, 8'h02);
      check(pcnt_value, 8'h02);
      wr(REG_PCNT_CFG, 8'h0F);
      wr(REG_PCNT_RAW, 8'h00);
      field_u.pulses(7, 3);
      drive(8'h00, 8'h00, 8);
      rd(REG_PCNT_RAW, 8'h06);
      rd(REG_PCNT_VALUE, 8'h03);
      wr(REG_PCNT_CFG, 8'h1F);
      drive(8'h00, 8'h00, 4);
      check(pcnt_value, 32'hFFFF_FFFD);
      rd(REG_PCNT_VALUE, 32'hFFFF_FFFD);
      $display("meter done");
      wrap_up();
   end
endmodule // bic_top_test
